//--- hw/dlp_pkg.sv
/*
 * Shared constants and types of the drive limit prohibition block:
 * APB register offsets, field positions, reset values, limit modes,
 * stop methods, status bit positions and the stop control carrier.
 * Assumes a single 10 MHz control clock and a 32-bit APB register bus.
 */
package dlp_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam int unsigned DLP_ADDR_W        = 8;
    localparam logic [7:0]  DLP_OFS_CFG       = 8'h00;
    localparam logic [7:0]  DLP_OFS_INSEL1    = 8'h04;
    localparam logic [7:0]  DLP_OFS_INSEL2    = 8'h08;
    localparam logic [7:0]  DLP_OFS_QSTOP_TRQ = 8'h0C;
    localparam logic [7:0]  DLP_OFS_OFLOW_LVL = 8'h10;
    localparam logic [7:0]  DLP_OFS_OVRUN_LVL = 8'h14;
    localparam logic [7:0]  DLP_OFS_STATUS    = 8'h18;
    localparam logic [7:0]  DLP_OFS_MASK      = 8'h1C;
    localparam logic [7:0]  DLP_OFS_STATE     = 8'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned DLP_CFG_MODE_LSB  = 0;
    localparam int unsigned DLP_CFG_STOP_LSB  = 4;
    localparam int unsigned DLP_SEL_POS_LSB   = 0;
    localparam int unsigned DLP_SEL_SPD_LSB   = 8;
    localparam int unsigned DLP_SEL_NC_BIT    = 7;
    localparam int unsigned DLP_ST_PROHIB     = 0;
    localparam int unsigned DLP_ST_OFLOW      = 1;
    localparam int unsigned DLP_ST_OVRUN      = 2;
    localparam int unsigned DLP_ST_FWD        = 3;
    localparam int unsigned DLP_ST_REV        = 4;
    localparam int unsigned DLP_ST_W          = 5;

    // ************************************************************
    // Codes and reset values
    // ************************************************************
    localparam logic [6:0]  DLP_FN_FWD        = 7'h01;
    localparam logic [6:0]  DLP_FN_REV        = 7'h02;
    localparam logic [1:0]  DLP_MODE_STOP     = 2'h0;
    localparam logic [1:0]  DLP_MODE_OFF      = 2'h1;
    localparam logic [1:0]  DLP_MODE_ALARM    = 2'h2;
    localparam logic [1:0]  DLP_STOP_DYNBRK   = 2'h0;
    localparam logic [1:0]  DLP_STOP_FREERUN  = 2'h1;
    localparam logic [1:0]  DLP_STOP_QUICK    = 2'h2;
    localparam logic [1:0]  DLP_RST_MODE      = 2'h1;
    localparam logic [1:0]  DLP_RST_STOP      = 2'h0;
    localparam logic [31:0] DLP_RST_INSEL1    = 32'h00828282;
    localparam logic [31:0] DLP_RST_INSEL2    = 32'h00818181;
    localparam logic [15:0] DLP_RST_QSTOP_TRQ = 16'h0000;
    localparam logic [31:0] DLP_RST_OFLOW_LVL = 32'h00010000;
    localparam logic [31:0] DLP_RST_OVRUN_LVL = 32'h00020000;
    localparam logic [15:0] DLP_TRQ_UNLIMITED = 16'hFFFF;

    // Stop sequence commands towards motion and error counter logic
    typedef struct packed {
        logic dyn_brake;
        logic free_run;
        logic quick_stop;
        logic servo_lock;
        logic fwd_torque_zero;
        logic rev_torque_zero;
        logic err_hold;
        logic err_clear;
    } dlp_stop_ctl_t;

endpackage

//--- hw/dlp_term_decode.sv
/*
 * Limit terminal decoder: synchronises each contact input and maps it
 * through its input selector to the forward or reverse limit function.
 * Assumes pins are asynchronous to clk and selectors are static-ish.
 */
module dlp_term_decode #(
    parameter int unsigned N_TERM = 2
) (
    input  wire logic                   clk,       // Control clock
    input  wire logic                   reset_n,   // Sync reset, low
    input  wire logic [N_TERM-1:0]      term_pin,  // 1 = contact shorted
    input  wire logic [N_TERM-1:0][31:0] term_sel, // Selector per terminal
    input  wire logic                   pos_ctrl,  // 1 = position control
    output logic                        fwd_trip,  // Forward limit active
    output logic                        rev_trip   // Reverse limit active
);
    import dlp_pkg::*;

    logic [N_TERM-1:0] sync_a;
    logic [N_TERM-1:0] sync_b;
    logic [N_TERM-1:0] fwd_hit;
    logic [N_TERM-1:0] rev_hit;

    // ************************************************************
    // Per-terminal synchroniser and function decode
    // ************************************************************
    for (genvar t = 0; t < N_TERM; t++) begin : g_term
        logic [7:0] fn;
        logic       active;

        // Two stages so a metastable pin sample never reaches the decision logic; contact bounce is not filtered
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                sync_a[t] <= 1'b0;
                sync_b[t] <= 1'b0;
            end else begin
                sync_a[t] <= term_pin[t];
                sync_b[t] <= sync_a[t];
            end
        end

        // Control mode picks the selector byte; NC logic trips on open
        assign fn = pos_ctrl ? term_sel[t][DLP_SEL_POS_LSB +: 8]
                             : term_sel[t][DLP_SEL_SPD_LSB +: 8];
        assign active = fn[DLP_SEL_NC_BIT] ? ~sync_b[t] : sync_b[t];
        assign fwd_hit[t] = active && (fn[6:0] == DLP_FN_FWD);
        assign rev_hit[t] = active && (fn[6:0] == DLP_FN_REV);
    end

    // Any terminal carrying the function can trip it
    assign fwd_trip = |fwd_hit;
    assign rev_trip = |rev_hit;

endmodule

//--- hw/dlp_limit_ctrl.sv
/*
 * Drive limit prohibition controller: watches the forward and reverse
 * travel limits, blocks motion toward a tripped limit, runs the chosen
 * stop sequence, raises the prohibition, overflow and overrun alarms,
 * and caps torque during an immediate stop. APB slave for settings.
 * Assumes motion logic reports zero speed and absolute position error.
 */

// How it works
// - Inactive limit input stops the motor
// - Selectors default to reverse, forward, NC
// - Mode 0: open forward blocks forward only
// - Mode 0: open reverse blocks reverse only
// - Mode 0: both open raises prohibition alarm
// - Mode 1 ignores both limit inputs
// - Mode 2: either open raises alarm
// - Mode 0 trip runs selected stop sequence
// - Brake or free-run, zero torque, hold counter
// - Immediate stop, servo lock, clear counter twice
// - Immediate stop caps torque at setting
// - Prohibition inactive by default until mode set
// - Selectors choose terminal and contact logic
// - Fast-stop position error raises overflow/overrun
module dlp_limit_ctrl (
    input  wire logic                  clk,           // 10 MHz control clock
    input  wire logic                  reset_n,       // Sync reset, low
    input  wire logic                  psel,          // APB select
    input  wire logic                  penable,       // APB enable
    input  wire logic                  pwrite,        // APB write
    input  wire logic [7:0]            paddr,         // APB byte address
    input  wire logic [31:0]           pwdata,        // APB write data
    output logic [31:0]                prdata,        // APB read data
    output logic                       pready,        // APB ready
    output logic                       pslverr,       // APB error
    input  wire logic [1:0]            term_pin,      // Limit contacts, 1=shorted
    input  wire logic                  pos_ctrl,      // 1 = position control
    input  wire logic                  motor_stopped, // Zero speed reached
    input  wire logic [31:0]           pos_err_abs,   // Position error size
    output dlp_pkg::dlp_stop_ctl_t     stop_ctl,      // Stop sequence commands
    output logic [15:0]                torque_limit,  // Torque ceiling
    output logic                       alarm_prohib,  // Prohibition alarm
    output logic                       alarm_oflow,   // Counter overflow alarm
    output logic                       alarm_ovrun,   // Overrun alarm
    output logic                       irq            // Interrupt, level
);
    import dlp_pkg::*;

    typedef enum logic [1:0] {DLP_IDLE, DLP_DECEL, DLP_HOLD} dlp_state_t;

    logic [1:0]          limit_mode;
    logic [1:0]          limit_stop_method;
    logic [31:0]         input_sel_first;
    logic [31:0]         input_sel_second;
    logic [15:0]         quick_stop_torque;
    logic [31:0]         pos_err_overflow_level;
    logic [31:0]         overrun_level;
    logic [DLP_ST_W-1:0] status;
    logic [DLP_ST_W-1:0] mask;
    logic [DLP_ST_W-1:0] events;
    logic                fwd_trip;
    logic                rev_trip;
    logic                fwd_forbid;
    logic                rev_forbid;
    logic                fwd_forbid_q;
    logic                rev_forbid_q;
    logic                prohib_c;
    logic                oflow_c;
    logic                ovrun_c;
    logic                trip_any;
    logic [1:0]          method_q;
    dlp_state_t          state;
    dlp_state_t          next_state;
    dlp_stop_ctl_t       next_ctl;
    logic                apb_acc;
    logic                apb_wr;
    logic                hit;
    logic [31:0]         rd_mux;

    // ************************************************************
    // Limit terminals
    // ************************************************************
    dlp_term_decode #(
        .N_TERM (2)
    ) u_decode (
        .clk      (clk),
        .reset_n  (reset_n),
        .term_pin (term_pin),
        .term_sel ({input_sel_second, input_sel_first}),
        .pos_ctrl (pos_ctrl),
        .fwd_trip (fwd_trip),
        .rev_trip (rev_trip)
    );

    // ************************************************************
    // Prohibition and alarm decisions
    // ************************************************************
    // Mode 1 (and the unused code 3) leave both limits without effect
    assign fwd_forbid = fwd_trip && (limit_mode == DLP_MODE_STOP
                        || limit_mode == DLP_MODE_ALARM);
    assign rev_forbid = rev_trip && (limit_mode == DLP_MODE_STOP
                        || limit_mode == DLP_MODE_ALARM);
    assign trip_any   = fwd_forbid || rev_forbid;
    assign prohib_c   = (limit_mode == DLP_MODE_STOP && fwd_trip && rev_trip)
                     || (limit_mode == DLP_MODE_ALARM && (fwd_trip || rev_trip));
    // Only the fast stop can overshoot enough to matter here
    assign oflow_c = pos_ctrl && state == DLP_DECEL && method_q == DLP_STOP_QUICK
                     && pos_err_abs > pos_err_overflow_level;
    assign ovrun_c = pos_ctrl && state == DLP_DECEL && method_q == DLP_STOP_QUICK
                     && pos_err_abs > overrun_level;

    // Alarm outputs follow their conditions one cycle late
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alarm_prohib <= 1'b0;
            alarm_oflow  <= 1'b0;
            alarm_ovrun  <= 1'b0;
            fwd_forbid_q <= 1'b0;
            rev_forbid_q <= 1'b0;
        end else begin
            alarm_prohib <= prohib_c;
            alarm_oflow  <= oflow_c;
            alarm_ovrun  <= ovrun_c;
            fwd_forbid_q <= fwd_forbid;
            rev_forbid_q <= rev_forbid;
        end
    end

    // ************************************************************
    // Stop sequence
    // ************************************************************
    // Method is latched at the trip so a late setting change cannot
    // switch braking style in the middle of a deceleration
    always_comb begin
        next_state = state;
        next_ctl   = '0;
        case (state)
            DLP_IDLE: begin
                if (trip_any) begin
                    next_state = DLP_DECEL;
                end
            end
            DLP_DECEL: begin
                if (!trip_any) begin
                    next_state = DLP_IDLE;
                end else if (motor_stopped) begin
                    next_state = DLP_HOLD;
                end
            end
            DLP_HOLD: begin
                if (!trip_any) begin
                    next_state = DLP_IDLE;
                end
            end
            default: begin
                next_state = DLP_IDLE;
            end
        endcase
        if (next_state == DLP_DECEL) begin
            case (state == DLP_IDLE ? limit_stop_method : method_q)
                DLP_STOP_DYNBRK: begin
                    next_ctl.dyn_brake = 1'b1;
                    next_ctl.err_hold  = 1'b1;
                end
                DLP_STOP_FREERUN: begin
                    next_ctl.free_run        = 1'b1;
                    next_ctl.fwd_torque_zero = fwd_forbid;
                    next_ctl.rev_torque_zero = rev_forbid;
                    next_ctl.err_hold        = 1'b1;
                end
                DLP_STOP_QUICK: begin
                    next_ctl.quick_stop = 1'b1;
                    next_ctl.err_clear  = (state == DLP_IDLE);
                end
                default: begin
                    next_ctl.dyn_brake = 1'b1;
                    next_ctl.err_hold  = 1'b1;
                end
            endcase
        end else if (next_state == DLP_HOLD) begin
            if (method_q == DLP_STOP_QUICK) begin
                next_ctl.servo_lock = 1'b1;
                next_ctl.err_clear  = (state == DLP_DECEL);
            end else begin
                next_ctl.fwd_torque_zero = fwd_forbid;
                next_ctl.rev_torque_zero = rev_forbid;
                next_ctl.err_hold        = 1'b1;
            end
        end
    end

    // State, method latch and command outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state        <= DLP_IDLE;
            method_q     <= DLP_RST_STOP;
            stop_ctl     <= '0;
            torque_limit <= DLP_TRQ_UNLIMITED;
        end else begin
            state    <= next_state;
            stop_ctl <= next_ctl;
            if (state == DLP_IDLE && trip_any) begin
                method_q <= limit_stop_method;
            end
            torque_limit <= next_ctl.quick_stop ? quick_stop_torque
                                                : DLP_TRQ_UNLIMITED;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    // One wait state: pready is a flop so all outputs stay registered
    assign apb_acc = psel && penable && !pready;
    assign apb_wr  = psel && penable && pready && pwrite;
    assign events  = {rev_forbid && !rev_forbid_q, fwd_forbid && !fwd_forbid_q,
                      ovrun_c && !alarm_ovrun, oflow_c && !alarm_oflow,
                      prohib_c && !alarm_prohib};

    // Read decode and map membership
    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            DLP_OFS_CFG: begin
                rd_mux[DLP_CFG_MODE_LSB +: 2] = limit_mode;
                rd_mux[DLP_CFG_STOP_LSB +: 2] = limit_stop_method;
            end
            DLP_OFS_INSEL1:    rd_mux = input_sel_first;
            DLP_OFS_INSEL2:    rd_mux = input_sel_second;
            DLP_OFS_QSTOP_TRQ: rd_mux[15:0] = quick_stop_torque;
            DLP_OFS_OFLOW_LVL: rd_mux = pos_err_overflow_level;
            DLP_OFS_OVRUN_LVL: rd_mux = overrun_level;
            DLP_OFS_STATUS:    rd_mux[DLP_ST_W-1:0] = status;
            DLP_OFS_MASK:      rd_mux[DLP_ST_W-1:0] = mask;
            DLP_OFS_STATE: begin
                rd_mux[1:0] = state;
                rd_mux[2]   = fwd_forbid;
                rd_mux[3]   = rev_forbid;
                rd_mux[5:4] = method_q;
            end
            default: hit = 1'b0;
        endcase
    end

    // Bus answer flops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc && !hit;
            prdata  <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Settings registers; selectors default to NC limit mapping
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            limit_mode             <= DLP_RST_MODE;
            limit_stop_method      <= DLP_RST_STOP;
            input_sel_first        <= DLP_RST_INSEL1;
            input_sel_second       <= DLP_RST_INSEL2;
            quick_stop_torque      <= DLP_RST_QSTOP_TRQ;
            pos_err_overflow_level <= DLP_RST_OFLOW_LVL;
            overrun_level          <= DLP_RST_OVRUN_LVL;
            mask                   <= '0;
        end else if (apb_wr) begin
            case (paddr)
                DLP_OFS_CFG: begin
                    limit_mode        <= pwdata[DLP_CFG_MODE_LSB +: 2];
                    limit_stop_method <= pwdata[DLP_CFG_STOP_LSB +: 2];
                end
                DLP_OFS_INSEL1:    input_sel_first        <= pwdata;
                DLP_OFS_INSEL2:    input_sel_second       <= pwdata;
                DLP_OFS_QSTOP_TRQ: quick_stop_torque      <= pwdata[15:0];
                DLP_OFS_OFLOW_LVL: pos_err_overflow_level <= pwdata;
                DLP_OFS_OVRUN_LVL: overrun_level          <= pwdata;
                DLP_OFS_MASK:      mask                   <= pwdata[DLP_ST_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky events: a set in the clearing cycle wins over the clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~((apb_wr && paddr == DLP_OFS_STATUS)
                      ? pwdata[DLP_ST_W-1:0] : '0)) | events;
            irq    <= |(((status & ~((apb_wr && paddr == DLP_OFS_STATUS)
                      ? pwdata[DLP_ST_W-1:0] : '0)) | events) & mask);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_mode1_silent: assert property (limit_mode == DLP_MODE_OFF |=> !alarm_prohib)
        else $error("alarm raised with limits ignored");
    a_both_open_alarm: assert property (
        limit_mode == DLP_MODE_STOP && fwd_trip && rev_trip |=> alarm_prohib)
        else $error("both limits open without alarm");
    a_either_alarm: assert property (
        limit_mode == DLP_MODE_ALARM && (fwd_trip || rev_trip) |=> alarm_prohib)
        else $error("mode 2 limit open without alarm");
    a_trip_starts_stop: assert property (
        state == DLP_IDLE && limit_mode == DLP_MODE_STOP && fwd_trip
        |=> state == DLP_DECEL)
        else $error("trip did not start deceleration");
    a_brake_holds_err: assert property (
        state == DLP_DECEL && method_q == DLP_STOP_DYNBRK
        |-> stop_ctl.dyn_brake && stop_ctl.err_hold && !stop_ctl.err_clear)
        else $error("dynamic brake stop wrong commands");
    a_hold_torque_zero: assert property (
        state == DLP_HOLD && method_q != DLP_STOP_QUICK && $past(state) == DLP_HOLD
        |-> stop_ctl.fwd_torque_zero == $past(fwd_forbid)
        && stop_ctl.rev_torque_zero == $past(rev_forbid) && stop_ctl.err_hold)
        else $error("torque not zeroed toward limit in hold");
    a_quick_clear_twice: assert property (
        state == DLP_DECEL && method_q == DLP_STOP_QUICK && trip_any && motor_stopped
        |=> stop_ctl.err_clear && stop_ctl.servo_lock ##1 !stop_ctl.err_clear)
        else $error("counter not cleared after immediate stop");
    a_quick_clear_entry: assert property (
        state == DLP_IDLE && trip_any && limit_stop_method == DLP_STOP_QUICK
        |=> stop_ctl.err_clear && stop_ctl.quick_stop
        ##1 (!stop_ctl.err_clear || stop_ctl.servo_lock))
        else $error("counter clear pulse wrong at immediate stop");
    a_torque_cap: assert property (
        stop_ctl.quick_stop && $stable(quick_stop_torque)
        |-> torque_limit == quick_stop_torque)
        else $error("torque not capped during immediate stop");
    a_oflow_alarm: assert property (
        pos_ctrl && state == DLP_DECEL && method_q == DLP_STOP_QUICK
        && pos_err_abs > pos_err_overflow_level |=> alarm_oflow)
        else $error("overflow alarm missing in fast stop");
    a_release_idle: assert property (
        state != DLP_IDLE && !trip_any |=> state == DLP_IDLE && stop_ctl == '0)
        else $error("stop kept after limits released");

    c_quick_hold: cover property (state == DLP_DECEL && method_q == DLP_STOP_QUICK
                                  ##[1:50] state == DLP_HOLD);
    c_freerun_hold: cover property (stop_ctl.free_run ##[1:50] state == DLP_HOLD);
    c_prohib_irq: cover property (alarm_prohib ##[1:3] irq);
    c_oflow: cover property (alarm_oflow);

endmodule

//--- sim/dlp_switch_model.sv
/* Pair of machine limit switches on the control inputs.
 * Assumes default selectors: bit0 reverse, bit1 forward, NC. */
module dlp_switch_model (
    input  wire logic       fwd_open, // Forward switch open
    input  wire logic       rev_open, // Reverse switch open
    output logic [1:0]      term_pin  // 1 = contact shorted
);
    timeunit 1ns;
    timeprecision 1ns;
    // NC wiring, so an open switch reads 0 at the pin
    assign term_pin = {~fwd_open, ~rev_open};
endmodule

//--- sim/tb_drive_limit_prohibition.sv
/* Bench for dlp_limit_ctrl: reset values, modes, stop and irq.
 * Assumes a 10 MHz clock and the limit switch model. */
module tb_drive_limit_prohibition;
    timeunit 1ns;
    timeprecision 1ns;
    import dlp_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] v;} dlp_row_t;
    logic          clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic          stopped, f_open, r_open, a_pro, a_ofl, a_ovr, pc, irq, err;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, perr, rd;
    logic [1:0]    term_pin;
    logic [15:0]   trq;
    dlp_stop_ctl_t stop_ctl;
    int            miscompares, samples_checked, cyc;
    dlp_row_t rows[8] = '{'{8'h00, 32'h1}, '{8'h04, 32'h00828282},
        '{8'h08, 32'h00818181}, '{8'h0C, 32'h0}, '{8'h10, 32'h00010000},
        '{8'h14, 32'h00020000}, '{8'h1C, 32'h0}, '{8'h40, 32'h0}};
    dlp_switch_model sw_u (.fwd_open(f_open), .rev_open(r_open), .term_pin(term_pin));
    dlp_limit_ctrl dut_u (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .term_pin(term_pin), .pos_ctrl(pc), .motor_stopped(stopped),
        .pos_err_abs(perr), .stop_ctl(stop_ctl), .torque_limit(trq),
        .alarm_prohib(a_pro), .alarm_oflow(a_ofl), .alarm_ovrun(a_ovr), .irq(irq));
    // Clock
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // Hang guard, well above the roughly 130 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            give_verdict();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer, held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk); penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {stopped, f_open, r_open, perr, miscompares, samples_checked, cyc} = '0;
        pc = 1'b1;
        wt(16);
        chk("reset torque", 32'hFFFF, {16'h0, trq});
        reset_n <= 1;
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            chk("register", rows[i].v, rd);
            chk("slverr", {31'h0, rows[i].a == 8'h40}, {31'h0, err});
        end
        $display("register reset test done");
        f_open <= 1; r_open <= 1; wt(5);
        chk("mode1", 0, {a_pro, stop_ctl});
        f_open <= 0; r_open <= 0; wt(3);
        apb(1, 8'h0C, 32'h0123);
        apb(1, 8'h00, 32'h20);
        apb(1, 8'h1C, 32'h1F);
        f_open <= 1; wt(5);
        chk("qstop ctl", 8'h20, stop_ctl);
        chk("qstop trq", 32'h0123, {16'h0, trq});
        chk("fwd alarm", 0, a_pro);
        chk("irq", 1, irq);
        perr <= 32'h00010001; wt(3);
        chk("oflow", 1, a_ofl);
        chk("ovrun low", 0, a_ovr);
        perr <= 32'h00020001; wt(2);
        chk("ovrun", 1, a_ovr);
        perr <= 0; stopped <= 1; wt(3);
        chk("lock ctl", 8'h10, stop_ctl);
        r_open <= 1; wt(4);
        chk("both alarm", 1, a_pro);
        f_open <= 0; r_open <= 0; stopped <= 0; wt(5);
        chk("release", 0, stop_ctl);
        apb(1, 8'h18, 32'h1F); wt(2);
        chk("irq clear", 0, irq);
        apb(1, 8'h08, 32'h81);
        pc <= 0; f_open <= 1; wt(5);
        chk("speed sel", 0, stop_ctl);
        f_open <= 0; wt(3);
        pc <= 1;
        $display("mode 0 test done");
        apb(1, 8'h00, 32'h02);
        r_open <= 1; wt(5);
        chk("mode2 alarm", 1, a_pro);
        chk("brake ctl", 8'h82, stop_ctl);
        stopped <= 1; wt(3);
        chk("hold ctl", 8'h06, stop_ctl);
        apb(1, 8'h1C, 32'h0); wt(2);
        chk("irq masked", 0, irq);
        $display("mode 2 test done");
        give_verdict();
    end
endmodule
